// ---- src/bhf_cfg.svh ----
// register map, field positions, reset values and timing of the b-channel hdlc block
`ifndef BHF_CFG_SVH
`define BHF_CFG_SVH
// register offsets
`define BHF_A_RXF 8'h80
`define BHF_A_TXF 8'h84
`define BHF_A_CMD 8'h88
`define BHF_A_MODE 8'h8C
`define BHF_A_EV 8'h90
`define BHF_A_EVM 8'h94
`define BHF_A_STAT 8'h98
`define BHF_A_ADM1 8'h9C
`define BHF_A_ADM2 8'hA0
`define BHF_A_ADR1 8'hA4
`define BHF_A_ADR2 8'hA8
`define BHF_A_LENL 8'hAC
`define BHF_A_LENH 8'hB0
`define BHF_A_IDLE 8'hB4
// command bits
`define BHF_C_RX_ACKNOWLEDGE_CMD 7
`define BHF_C_RX_RESET_CMD 6
`define BHF_C_RX_ACTIVE_BIT 5
`define BHF_C_XACTN 4
`define BHF_C_COMB 3
`define BHF_C_XMS 2
`define BHF_C_XME 1
`define BHF_C_TX_RESET_CMD 0
// mode bits
`define BHF_M_MMS 7
`define BHF_M_ITF 6
`define BHF_M_FTS 1:0
// event and status bits
`define BHF_E_RMR 6
`define BHF_E_RME 5
`define BHF_E_OVF 4
`define BHF_E_XFR 1
`define BHF_E_TX_UNDERRUN_EVENT 0
`define BHF_E_USED 8'h73
`define BHF_S_OVF 6
`define BHF_S_CRCE 5
`define BHF_S_ABORT 4
`define BHF_S_XDOW 2
`define BHF_S_BUSY 0
`define BHF_H_LOV 5
// reset values
`define BHF_R_MODE 8'h00
`define BHF_R_EVM 8'hFF
`define BHF_R_ADDR 8'h00
`define BHF_R_IDLE 8'hFF
// thresholds, patterns, crc
`define BHF_FTS_96 2'h2
`define BHF_THR_64 8'h40
`define BHF_THR_96 8'h60
`define BHF_FLAG 8'h7E
`define BHF_MARK 8'hFF
`define BHF_CRC_INIT 16'hFFFF
`define BHF_CRC_POLY 16'h8408
`define BHF_LEN_MAX 13'h1FFF
// line clock timing
`define BHF_SYS_KHZ 100000
`define BHF_BCLK_KHZ 64
`define BHF_BCLK_HALF (`BHF_SYS_KHZ / (2 * `BHF_BCLK_KHZ))
`endif

// ---- src/bhf_pkg.sv ----
// types shared by the b-channel hdlc block
package bhf_pkg;
  // transmit byte sequencer
  typedef enum logic [1:0] {BHF_TX_IDLE, BHF_TX_DATA, BHF_TX_CRC1, BHF_TX_CRC2} bhf_tx_st_t;
endpackage : bhf_pkg

// ---- src/bhf_channel.sv ----
// b-channel hdlc controller: fifos, command register, framer and deframer
`timescale 1ns/1ps
`include "bhf_cfg.svh"
module bhf_channel #(
  parameter int DEPTH = 128, // fifo depth, both directions
  parameter int AW = 7 // fifo pointer width
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_rx_tick,
  input wire logic i_rx_bit,
  input wire logic i_tx_tick,
  output logic o_tx_bit,
  output logic o_rx_clock,
  output logic o_tx_clock,
  output logic o_combined_mode
);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [9:0] HALF = 10'(`BHF_BCLK_HALF - 1);

  // register decode
  wire wr_txf = i_write && (i_addr == `BHF_A_TXF);
  wire wr_cmd = i_write && (i_addr == `BHF_A_CMD);
  wire wr_mode = i_write && (i_addr == `BHF_A_MODE);
  wire wr_evm = i_write && (i_addr == `BHF_A_EVM);
  wire wr_adm1 = i_write && (i_addr == `BHF_A_ADM1);
  wire wr_adm2 = i_write && (i_addr == `BHF_A_ADM2);
  wire wr_adr1 = i_write && (i_addr == `BHF_A_ADR1);
  wire wr_adr2 = i_write && (i_addr == `BHF_A_ADR2);
  wire wr_idle = i_write && (i_addr == `BHF_A_IDLE);
  wire rd_rxf = i_read && (i_addr == `BHF_A_RXF);
  wire rd_ev = i_read && (i_addr == `BHF_A_EV);
  // command pulses are never stored, so they read back as zero
  wire rx_acknowledge_cmd_p = wr_cmd && i_wdata[`BHF_C_RX_ACKNOWLEDGE_CMD];
  wire rx_reset_cmd_p = wr_cmd && i_wdata[`BHF_C_RX_RESET_CMD];
  wire xms_p = wr_cmd && i_wdata[`BHF_C_XMS];
  wire xme_p = wr_cmd && i_wdata[`BHF_C_XME];
  wire tx_reset_cmd_p = wr_cmd && i_wdata[`BHF_C_TX_RESET_CMD];

  logic rx_act; // receiver active, high
  logic tx_act_n; // transmitter active, low
  logic comb; // both line channels merged
  logic [7:0] mode; // mode control
  logic [7:0] ev; // sticky events
  logic [7:0] evm; // event mask, one masks
  logic [7:0] adm1, adm2, adr1, adr2; // address compare values
  logic [7:0] idle_pat; // clear-channel idle byte
  logic [7:0] len_lo; // latched frame length
  logic [4:0] len_hi;
  logic len_lov;
  logic st_ovf, st_crce, st_abort, st_xdow;

  // mode decode
  wire framed = !mode[`BHF_M_MMS];
  wire interframe_fill_bit = mode[`BHF_M_ITF];
  // reserved select codes fall back to 64
  wire [AW:0] thr = (mode[`BHF_M_FTS] == `BHF_FTS_96) ? (AW+1)'(`BHF_THR_96)
                                                      : (AW+1)'(`BHF_THR_64);
  wire [7:0] fill = framed ? (interframe_fill_bit ? `BHF_FLAG : `BHF_MARK) : idle_pat;

  // ---------------- receive fifo
  logic [7:0] rx_mem [DEPTH];
  logic [AW-1:0] rx_wr, rx_rd;
  logic [AW:0] rx_n;
  wire rx_full = (rx_n == FULL);
  wire rx_pop = rd_rxf && (rx_n != '0);
  logic rx_push; // byte assembled
  logic [7:0] rx_byte;
  wire rx_wen = rx_push && !rx_full; // overflow drops the byte

  // storage, no reset needed for data
  always_ff @(posedge i_clock)
  begin
    if (rx_wen)
      rx_mem[rx_wr] <= rx_byte;
  end

  // receive pointers, flushed by receiver reset
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      rx_wr <= '0;
      rx_rd <= '0;
      rx_n <= '0;
    end
    else if (rx_reset_cmd_p)
    begin
      rx_wr <= '0;
      rx_rd <= '0;
      rx_n <= '0;
    end
    else
    begin
      rx_wr <= rx_wr + AW'(rx_wen);
      rx_rd <= rx_rd + AW'(rx_pop);
      rx_n <= rx_n + (AW+1)'(rx_wen) - (AW+1)'(rx_pop);
    end
  end

  // ---------------- deframer
  logic [7:0] rx_raw; // last eight line bits
  logic [7:0] rx_sh; // byte assembly
  logic [2:0] rx_bc; // bits in assembly
  logic [2:0] rx_ones; // run of ones, saturates
  logic in_frame;
  logic [12:0] rx_len;
  logic rx_lov;
  logic rx_armed; // receive-ready may fire
  wire rx_tk = i_rx_tick && rx_act;
  wire [7:0] raw_next = {i_rx_bit, rx_raw[7:1]};
  wire flag_hit = framed && rx_tk && (raw_next == `BHF_FLAG);
  wire abort_hit = framed && rx_tk && i_rx_bit && (rx_ones == 3'h6) && in_frame;
  wire destuff = framed && (rx_ones == 3'h5) && !i_rx_bit;
  // clear-channel keeps every bit, framed drops flags and stuffed zeros
  wire take = rx_tk && (framed ? (in_frame && !destuff && !flag_hit) : 1'b1);
  wire fe = flag_hit && in_frame && ((rx_len != '0) || rx_lov);
  assign rx_push = take && (rx_bc == 3'h7);
  assign rx_byte = {i_rx_bit, rx_sh[7:1]};
  wire set_rmr = rx_armed && (rx_n > thr);
  wire set_ovf = rx_push && rx_full;

  // bit assembly and frame tracking
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      rx_raw <= 8'h00;
      rx_sh <= 8'h00;
      rx_bc <= 3'h0;
      rx_ones <= 3'h0;
      in_frame <= 1'b0;
    end
    else if (rx_reset_cmd_p)
    begin
      rx_bc <= 3'h0;
      rx_ones <= 3'h0;
      in_frame <= 1'b0;
    end
    else if (rx_tk)
    begin
      rx_raw <= raw_next;
      rx_ones <= !i_rx_bit ? 3'h0 : (rx_ones == 3'h7) ? 3'h7 : rx_ones + 3'h1;
      if (take)
      begin
        rx_sh <= rx_byte;
        rx_bc <= rx_bc + 3'h1;
      end
      // a flag restarts byte alignment
      if (flag_hit)
      begin
        rx_bc <= 3'h0;
        in_frame <= 1'b1;
      end
      else if (abort_hit)
        in_frame <= 1'b0;
    end
  end

  // frame length and receive-ready arming
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      rx_len <= '0;
      rx_lov <= 1'b0;
      rx_armed <= 1'b1;
    end
    else
    begin
      if (rx_reset_cmd_p || flag_hit)
      begin
        rx_len <= '0;
        rx_lov <= 1'b0;
      end
      else if (rx_wen)
      begin
        rx_lov <= rx_lov || (rx_len == `BHF_LEN_MAX);
        rx_len <= (rx_len == `BHF_LEN_MAX) ? rx_len : rx_len + 13'h0001;
      end
      // acknowledge re-arms, so one event per block
      if (rx_acknowledge_cmd_p || rx_reset_cmd_p)
        rx_armed <= 1'b1;
      else if (set_rmr)
        rx_armed <= 1'b0;
    end
  end

  // length registers latch at frame end
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      len_lo <= 8'h00;
      len_hi <= 5'h00;
      len_lov <= 1'b0;
    end
    else if (fe)
    begin
      len_lo <= rx_len[7:0];
      len_hi <= rx_len[12:8];
      len_lov <= rx_lov;
    end
  end

  // ---------------- transmit fifo
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wr, tx_rd;
  logic [AW:0] tx_n;
  logic [7:0] sk0, sk1; // two-entry buffer to the serializer
  logic [1:0] sk_n;
  logic tx_flush; // reset or underrun
  logic sk_pop;
  // the two buffer entries count as fifo space, so software sees exactly DEPTH bytes
  wire [AW:0] tx_used = tx_n + (AW+1)'(sk_n);
  wire tx_full = (tx_used == FULL);
  wire tx_wen = wr_txf && !tx_full;
  wire sk_push = (tx_n != '0) && (sk_n != 2'h2) && !tx_flush;
  wire [1:0] sk_wi = sk_n - {1'b0, sk_pop};
  wire [AW:0] tx_free = FULL - tx_used;
  wire space_ok = (tx_free >= thr);
  logic space_q;
  wire set_xfr = (space_ok && !space_q) || tx_reset_cmd_p;

  // storage
  always_ff @(posedge i_clock)
  begin
    if (tx_wen)
      tx_mem[tx_wr] <= i_wdata;
  end

  // transmit pointers
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      tx_wr <= '0;
      tx_rd <= '0;
      tx_n <= '0;
    end
    else if (tx_flush)
    begin
      tx_wr <= '0;
      tx_rd <= '0;
      tx_n <= '0;
    end
    else
    begin
      tx_wr <= tx_wr + AW'(tx_wen);
      tx_rd <= tx_rd + AW'(sk_push);
      tx_n <= tx_n + (AW+1)'(tx_wen) - (AW+1)'(sk_push);
    end
  end

  // buffer stalls the fifo when the serializer is slow
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      sk_n <= 2'h0;
    else if (tx_flush)
      sk_n <= 2'h0;
    else
      sk_n <= sk_n + {1'b0, sk_push} - {1'b0, sk_pop};
  end

  // buffer data, a simultaneous push overrides the shift
  always_ff @(posedge i_clock)
  begin
    if (sk_pop)
      sk0 <= sk1;
    if (sk_push && (sk_wi == 2'h0))
      sk0 <= tx_mem[tx_rd];
    else if (sk_push)
      sk1 <= tx_mem[tx_rd];
  end

  // ---------------- framer
  bhf_pkg::bhf_tx_st_t tx_st, next_st;
  logic [7:0] tx_sh; // byte on the line
  logic [2:0] tx_bc;
  logic [2:0] tx_ones; // ones of stuffed bytes
  logic tx_raw; // byte goes out without stuffing
  logic tx_crc_en;
  logic [15:0] tx_crc;
  logic tx_go, tx_end;
  wire tx_tk = i_tx_tick && !tx_act_n;
  wire stuff = (tx_ones == 3'h5);
  wire adv = tx_tk && !stuff;
  wire bnd = adv && (tx_bc == 3'h7);
  wire [15:0] crc_upd = {1'b0, tx_crc[15:1]}
                        ^ ((tx_crc[0] ^ tx_sh[0]) ? `BHF_CRC_POLY : 16'h0000);
  wire [15:0] crc_cur = tx_crc_en ? crc_upd : tx_crc;
  logic [7:0] ld_byte;
  logic ld_raw, ld_crc_en, ld_pop, ld_done, ld_under, ld_init;

  // next byte at each byte boundary
  always_comb
  begin
    next_st = tx_st;
    ld_byte = fill;
    ld_raw = 1'b1;
    ld_crc_en = 1'b0;
    ld_pop = 1'b0;
    ld_done = 1'b0;
    ld_under = 1'b0;
    ld_init = 1'b0;
    case (tx_st)
      bhf_pkg::BHF_TX_IDLE:
        if (tx_go && framed)
        begin
          ld_byte = `BHF_FLAG;
          ld_init = 1'b1;
          next_st = bhf_pkg::BHF_TX_DATA;
        end
        else if (tx_go)
          next_st = bhf_pkg::BHF_TX_DATA;
      bhf_pkg::BHF_TX_DATA:
        if (sk_n != 2'h0)
        begin
          ld_byte = sk0;
          ld_raw = !framed;
          ld_crc_en = framed;
          ld_pop = 1'b1;
        end
        else if (tx_end && framed)
        begin
          ld_byte = ~crc_cur[7:0];
          ld_raw = 1'b0;
          next_st = bhf_pkg::BHF_TX_CRC1;
        end
        else if (tx_end || framed)
        begin
          // clear-channel end stops, framed empty fifo is an underrun
          next_st = bhf_pkg::BHF_TX_IDLE;
          ld_done = 1'b1;
          ld_under = !tx_end;
        end
      bhf_pkg::BHF_TX_CRC1:
      begin
        ld_byte = ~tx_crc[15:8];
        ld_raw = 1'b0;
        next_st = bhf_pkg::BHF_TX_CRC2;
      end
      bhf_pkg::BHF_TX_CRC2:
      begin
        ld_byte = `BHF_FLAG;
        ld_done = 1'b1;
        next_st = bhf_pkg::BHF_TX_IDLE;
      end
      default:
        next_st = bhf_pkg::BHF_TX_IDLE;
    endcase
  end
  assign sk_pop = bnd && ld_pop;
  assign tx_flush = tx_reset_cmd_p || (bnd && ld_under);

  // serializer with zero insertion
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      tx_st <= bhf_pkg::BHF_TX_IDLE;
      tx_sh <= `BHF_MARK;
      tx_bc <= 3'h0;
      tx_ones <= 3'h0;
      tx_raw <= 1'b1;
      tx_crc_en <= 1'b0;
      tx_crc <= `BHF_CRC_INIT;
      o_tx_bit <= 1'b1;
    end
    else if (tx_reset_cmd_p)
    begin
      tx_st <= bhf_pkg::BHF_TX_IDLE;
      tx_sh <= fill;
      tx_bc <= 3'h0;
      tx_ones <= 3'h0;
      tx_raw <= 1'b1;
      tx_crc_en <= 1'b0;
    end
    else if (tx_tk)
    begin
      o_tx_bit <= stuff ? 1'b0 : tx_sh[0];
      // raw bytes never count, a pending stuffed zero still goes out
      tx_ones <= (stuff || tx_raw || !tx_sh[0]) ? 3'h0 : tx_ones + 3'h1;
      if (adv)
      begin
        tx_bc <= tx_bc + 3'h1;
        tx_sh <= {1'b1, tx_sh[7:1]};
        tx_crc <= ld_init ? `BHF_CRC_INIT : crc_cur;
      end
      if (bnd)
      begin
        tx_st <= next_st;
        tx_sh <= ld_byte;
        tx_raw <= ld_raw;
        tx_crc_en <= ld_crc_en;
      end
    end
  end

  // start and end requests, a new request wins over completion
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      tx_go <= 1'b0;
      tx_end <= 1'b0;
    end
    else if (tx_reset_cmd_p)
    begin
      tx_go <= 1'b0;
      tx_end <= 1'b0;
    end
    else
    begin
      tx_go <= xms_p || (tx_go && !(bnd && ld_done));
      tx_end <= xme_p || (tx_end && !(bnd && ld_done));
    end
  end

  // ---------------- registers, events, status
  wire [7:0] ev_set = (8'(set_rmr) << `BHF_E_RMR) | (8'(fe) << `BHF_E_RME)
                      | (8'(set_ovf) << `BHF_E_OVF) | (8'(set_xfr) << `BHF_E_XFR)
                      | (8'(bnd && ld_under) << `BHF_E_TX_UNDERRUN_EVENT);
  wire [7:0] ev_clr = rd_ev ? (~evm & `BHF_E_USED) : 8'h00; // masked stay pending
  wire [7:0] cmd_rd = (8'(rx_act) << `BHF_C_RX_ACTIVE_BIT) | (8'(tx_act_n) << `BHF_C_XACTN)
                      | (8'(comb) << `BHF_C_COMB);
  wire [7:0] st_rd = (8'(st_ovf) << `BHF_S_OVF) | (8'(st_crce) << `BHF_S_CRCE)
                     | (8'(st_abort) << `BHF_S_ABORT) | (8'(st_xdow) << `BHF_S_XDOW)
                     | (8'(tx_go) << `BHF_S_BUSY);
  wire [7:0] lenh_rd = {2'b00, len_lov, len_hi};
  wire [7:0] rd_val =
    (i_addr == `BHF_A_RXF) ? rx_mem[rx_rd] :
    (i_addr == `BHF_A_CMD) ? cmd_rd :
    (i_addr == `BHF_A_MODE) ? mode :
    (i_addr == `BHF_A_EV) ? (ev & ~evm) :
    (i_addr == `BHF_A_EVM) ? evm :
    (i_addr == `BHF_A_STAT) ? st_rd :
    (i_addr == `BHF_A_ADM1) ? adm1 :
    (i_addr == `BHF_A_ADM2) ? adm2 :
    (i_addr == `BHF_A_ADR1) ? adr1 :
    (i_addr == `BHF_A_ADR2) ? adr2 :
    (i_addr == `BHF_A_LENL) ? len_lo :
    (i_addr == `BHF_A_LENH) ? lenh_rd :
    (i_addr == `BHF_A_IDLE) ? idle_pat : 8'h00;

  // software-written registers
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      rx_act <= 1'b0;
      tx_act_n <= 1'b0;
      comb <= 1'b0;
      mode <= `BHF_R_MODE;
      evm <= `BHF_R_EVM;
      {adm1, adm2, adr1, adr2} <= {4{`BHF_R_ADDR}};
      idle_pat <= `BHF_R_IDLE;
    end
    else
    begin
      if (wr_cmd)
      begin
        rx_act <= i_wdata[`BHF_C_RX_ACTIVE_BIT];
        tx_act_n <= i_wdata[`BHF_C_XACTN];
        comb <= i_wdata[`BHF_C_COMB];
      end
      if (wr_mode)
        mode <= i_wdata;
      if (wr_evm)
        evm <= i_wdata;
      if (wr_adm1)
        adm1 <= i_wdata;
      if (wr_adm2)
        adm2 <= i_wdata;
      if (wr_adr1)
        adr1 <= i_wdata;
      if (wr_adr2)
        adr2 <= i_wdata;
      if (wr_idle)
        idle_pat <= i_wdata;
    end
  end

  // events and status, a set wins over a clear, except st_abort where receiver reset wins
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      ev <= 8'h00;
      space_q <= 1'b1;
      st_ovf <= 1'b0;
      st_crce <= 1'b1;
      st_abort <= 1'b0;
      st_xdow <= 1'b0;
    end
    else
    begin
      ev <= (ev & ~ev_clr) | ev_set;
      space_q <= space_ok;
      st_ovf <= set_ovf || (st_ovf && !rx_reset_cmd_p);
      st_crce <= st_crce && !fe;
      st_abort <= (abort_hit && !rx_reset_cmd_p) || (st_abort && !rx_reset_cmd_p);
      st_xdow <= (wr_txf && tx_full) || (st_xdow && !tx_reset_cmd_p);
    end
  end

  // read data, line clocks and mode output
  logic [9:0] div;
  logic phase;
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_rdata <= 8'h00;
      div <= 10'h000;
      phase <= 1'b0;
      o_rx_clock <= 1'b0;
      o_tx_clock <= 1'b0;
      o_combined_mode <= 1'b0;
    end
    else
    begin
      if (i_read)
        o_rdata <= rd_val;
      div <= (div == HALF) ? 10'h000 : div + 10'h001;
      phase <= phase ^ (div == HALF);
      o_rx_clock <= rx_act && phase;
      o_tx_clock <= !tx_act_n && phase;
      o_combined_mode <= comb;
    end
  end

  // ---------------- checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_rx_off; !rx_act [*2]; endsequence
  sequence s_cmd_read; wr_cmd ##[1:2] (i_read && i_addr == `BHF_A_CMD); endsequence
  property p_rx_thr; set_rmr |=> ev[`BHF_E_RMR] && !rx_armed; endproperty
  a_rx_thr: assert property (p_rx_thr) else $error("no receive-ready");
  property p_rx_end; fe |=> ev[`BHF_E_RME] && len_lo == $past(rx_len[7:0]); endproperty
  a_rx_end: assert property (p_rx_end) else $error("frame end lost");
  property p_tx_rst; tx_reset_cmd_p |=> tx_n == '0 && sk_n == 2'h0 && !tx_go
    && ev[`BHF_E_XFR] && tx_st == bhf_pkg::BHF_TX_IDLE; endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("transmitter reset");
  property p_rx_rst; rx_reset_cmd_p |=> rx_n == '0 && !in_frame && rx_armed; endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("receiver reset");
  property p_rx_clk; s_rx_off |-> !o_rx_clock; endproperty
  a_rx_clk: assert property (p_rx_clk) else $error("rx clock not low");
  property p_self_clr; s_cmd_read |=> (o_rdata & 8'hC7) == 8'h00; endproperty
  a_self_clr: assert property (p_self_clr) else $error("command bit kept");
  property p_cmd_rb; wr_cmd |=> cmd_rd == ($past(i_wdata) & 8'h38); endproperty
  a_cmd_rb: assert property (p_cmd_rb) else $error("readback wrong");
  property p_thr; wr_mode && i_wdata[`BHF_M_FTS] == `BHF_FTS_96
    |=> thr == (AW+1)'(`BHF_THR_96); endproperty
  a_thr: assert property (p_thr) else $error("threshold wrong");
  property p_open; bnd && tx_st == bhf_pkg::BHF_TX_IDLE && tx_go && framed
    |=> tx_sh == `BHF_FLAG && tx_raw ##8 tx_st == bhf_pkg::BHF_TX_DATA; endproperty
  a_open: assert property (p_open) else $error("no opening flag");
  property p_idle; bnd && tx_st == bhf_pkg::BHF_TX_IDLE && !tx_go && !framed
    |=> tx_sh == $past(idle_pat) && tx_raw; endproperty
  a_idle: assert property (p_idle) else $error("idle pattern");
endmodule : bhf_channel

// ---- verification/bhf_line_model.sv ----
// line-side model: bit ticks, receive bit source, transmit bit capture
`timescale 1ns/1ps
module bhf_line_model #(
  parameter int PER = 4 // cycles per line bit
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_tx_bit,
  output logic o_rx_tick,
  output logic o_rx_bit,
  output logic o_tx_tick,
  output logic [15:0] o_tx_win
);
  logic [7:0] q[$]; // bytes waiting for the line
  logic [7:0] sr; // byte in flight, lsb first
  int cnt; // tick divider
  int left; // bits left in sr
  assign o_tx_tick = o_rx_tick;
  // queue a byte for the receive line
  task automatic send(input logic [7:0] b);
    q.push_back(b);
  endtask : send
  // one tick each PER cycles; bits change only at a tick edge
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt <= 0;
      left <= 0;
      o_rx_tick <= 1'b0;
      o_rx_bit <= 1'b1;
      o_tx_win <= 16'h0000;
    end
    else
    begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      o_rx_tick <= (cnt == PER - 1);
      if (o_rx_tick)
      begin
        // tx bit seen here was launched after the previous tick
        o_tx_win <= {i_tx_bit, o_tx_win[15:1]};
        if (left > 0)
        begin
          o_rx_bit <= sr[0];
          sr <= sr >> 1;
          left <= left - 1;
        end
        else if (q.size() > 0)
        begin
          o_rx_bit <= q[0][0];
          sr <= q[0] >> 1;
          left <= 7;
          void'(q.pop_front());
        end
        else
          o_rx_bit <= 1'b1; // marks between frames
      end
    end
  end
endmodule : bhf_line_model

// ---- verification/tb.sv ----
// self-checking bench for the b-channel hdlc block
`timescale 1ns/1ps
`include "bhf_cfg.svh"
module tb;
  logic i_clock, i_reset, i_write, i_read, rx_tick, rx_bit, tx_tick, o_tx_bit;
  logic o_rx_clock, o_tx_clock, o_combined_mode;
  logic [7:0] i_addr, i_wdata, o_rdata, rd, acc;
  logic [15:0] win;
  int fail_count, num_checks;
  bhf_channel u_bhf_channel (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
    .i_write(i_write), .i_read(i_read), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_rx_tick(rx_tick), .i_rx_bit(rx_bit), .i_tx_tick(tx_tick), .o_tx_bit(o_tx_bit),
    .o_rx_clock(o_rx_clock), .o_tx_clock(o_tx_clock), .o_combined_mode(o_combined_mode));
  bhf_line_model u_bhf_line_model (.i_clock(i_clock), .i_reset(i_reset),
    .i_tx_bit(o_tx_bit), .o_rx_tick(rx_tick), .o_rx_bit(rx_bit), .o_tx_tick(tx_tick),
    .o_tx_win(win));
  // free-running system clock
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp8
  // one write: strobe held for exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) #1;
    i_addr = a;
    i_wdata = d;
    i_write = 1'b1;
    @(posedge i_clock) #1;
    i_write = 1'b0;
  endtask : wr
  // one read; data sampled a full cycle later, it holds until the next read
  task automatic rdr(input logic [7:0] a);
    @(posedge i_clock) #1;
    i_addr = a;
    i_read = 1'b1;
    @(posedge i_clock) #1;
    i_read = 1'b0;
    @(posedge i_clock) #1;
    rd = o_rdata;
  endtask : rdr
  // gather event bits until bit b shows, bounded
  task automatic poll(input int b);
    acc = 8'h00;
    for (int k = 0; k < 3000 && acc[b] !== 1'b1; k++)
    begin
      rdr(`BHF_A_EV);
      acc = acc | rd;
    end
  endtask : poll
  // true when w is some rotation of a repeated pattern p
  function automatic logic rot(input logic [7:0] w, input logic [7:0] p);
    logic [15:0] pp;
    pp = {p, p};
    rot = 1'b0;
    for (int k = 0; k < 8; k++)
      if (pp[k+:8] === w)
        rot = 1'b1;
  endfunction : rot
  task automatic t_reset;
    logic [7:0] ad[9] = '{8'h8C, 8'h94, 8'h88, 8'h98, 8'h90, 8'hB4, 8'h9C, 8'hAC, 8'h81};
    logic [7:0] ex[9] = '{8'h00, 8'hFF, 8'h00, 8'h20, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    cmp8({7'h00, o_tx_bit}, 8'h01, "idle line");
    for (int k = 0; k < 9; k++)
    begin
      rdr(ad[k]);
      cmp8(rd, ex[k], "reset value");
    end
  endtask : t_reset
  task automatic t_cmd;
    int hr;
    int ht;
    hr = 0;
    ht = 0;
    wr(`BHF_A_CMD, 8'h39);
    rdr(`BHF_A_CMD);
    cmp8(rd, 8'h38, "command readback");
    cmp8({7'h00, o_combined_mode}, 8'h01, "combined");
    repeat (1700)
    begin
      @(posedge i_clock) #1;
      hr += o_rx_clock;
      ht += o_tx_clock;
    end
    cmp8(8'(ht), 8'h00, "tx clock parked");
    cmp8({7'h00, hr >= 700 && hr <= 1000}, 8'h01, "rx clock runs");
  endtask : t_cmd
  task automatic t_txfifo;
    wr(`BHF_A_EVM, 8'h00);
    rdr(`BHF_A_EV);
    wr(`BHF_A_CMD, 8'h31);
    rdr(`BHF_A_EV);
    cmp8(rd & 8'h02, 8'h02, "space after reset");
    for (int k = 0; k < 128; k++)
      wr(`BHF_A_TXF, 8'(k));
    rdr(`BHF_A_STAT);
    cmp8(rd & 8'h04, 8'h00, "128 fit");
    wr(`BHF_A_TXF, 8'h55);
    rdr(`BHF_A_STAT);
    cmp8(rd & 8'h04, 8'h04, "overwritten");
    wr(`BHF_A_CMD, 8'h31);
    rdr(`BHF_A_STAT);
    cmp8(rd & 8'h04, 8'h00, "cleared by reset");
    rdr(`BHF_A_EV);
    cmp8(rd & 8'h02, 8'h02, "space again");
  endtask : t_txfifo
  task automatic t_fill;
    logic [7:0] md[3] = '{8'h00, 8'h40, 8'h80};
    logic [7:0] pt[3] = '{8'hFF, 8'h7E, 8'hA5};
    wr(`BHF_A_CMD, 8'h20);
    wr(`BHF_A_IDLE, 8'hA5);
    rdr(`BHF_A_IDLE);
    cmp8(rd, 8'hA5, "idle readback");
    for (int k = 0; k < 3; k++)
    begin
      wr(`BHF_A_MODE, md[k]);
      repeat (120) @(posedge i_clock);
      #1;
      cmp8({7'h00, rot(win[15:8], pt[k])}, 8'h01, "fill pattern");
    end
  endtask : t_fill
  task automatic t_frame;
    wr(`BHF_A_MODE, 8'h00);
    wr(`BHF_A_TXF, 8'h5A);
    wr(`BHF_A_CMD, 8'h26);
    rdr(`BHF_A_STAT);
    cmp8(rd & 8'h01, 8'h01, "busy");
    for (int k = 0; k < 300 && rd[0] !== 1'b0; k++)
      rdr(`BHF_A_STAT);
    cmp8(rd & 8'h01, 8'h00, "frame done");
    rdr(`BHF_A_EV);
    cmp8(rd & 8'h01, 8'h00, "no underrun");
  endtask : t_frame
  // clear-channel byte goes out unchanged between idle bytes, then sending stops
  task automatic t_clear;
    int seen;
    seen = 0;
    wr(`BHF_A_MODE, 8'h80);
    wr(`BHF_A_TXF, 8'h0F);
    wr(`BHF_A_CMD, 8'h26);
    repeat (300)
    begin
      @(posedge i_clock) #1;
      seen += (win[15:8] === 8'h0F);
    end
    cmp8(8'(seen > 0), 8'h01, "raw byte");
    rdr(`BHF_A_STAT);
    cmp8(rd & 8'h01, 8'h00, "stopped");
  endtask : t_clear
  // one received frame of n bytes under a threshold mode
  task automatic t_rx(input int n, input logic [7:0] md, input logic rx_threshold_event);
    int got;
    got = 0;
    // clear-channel scenarios leave stray bytes in the receive fifo
    wr(`BHF_A_CMD, 8'h60);
    wr(`BHF_A_MODE, md);
    u_bhf_line_model.send(`BHF_FLAG);
    for (int k = 0; k < n; k++)
      u_bhf_line_model.send(8'(k) & 8'h5B);
    u_bhf_line_model.send(`BHF_FLAG);
    if (rx_threshold_event)
    begin
      poll(`BHF_E_RMR);
      cmp8(acc & 8'h60, 8'h40, "threshold event");
      for (; got < 64; got++)
      begin
        rdr(`BHF_A_RXF);
        cmp8(rd, 8'(got) & 8'h5B, "rx byte");
      end
      wr(`BHF_A_CMD, 8'hA0);
    end
    poll(`BHF_E_RME);
    cmp8(acc & 8'h60, 8'h20, "frame end only");
    rdr(`BHF_A_LENL);
    cmp8(rd, 8'(n), "length low");
    rdr(`BHF_A_LENH);
    cmp8(rd, 8'h00, "length high");
    for (; got < n; got++)
    begin
      rdr(`BHF_A_RXF);
      cmp8(rd, 8'(got) & 8'h5B, "rx tail");
    end
    wr(`BHF_A_CMD, 8'hA0);
  endtask : t_rx
  // watchdog, far beyond the expected run
  initial
  begin
    #800000;
    fail_count++;
    end_sim();
  end
  initial
  begin
    {i_write, i_read, i_addr, i_wdata} = '0;
    fail_count = 0;
    num_checks = 0;
    i_reset = 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    i_reset = 1'b0;
    t_reset();
    t_cmd();
    t_txfifo();
    t_fill();
    t_frame();
    t_clear();
    t_rx(70, 8'h00, 1'b1);
    t_rx(70, 8'h02, 1'b0);
    end_sim();
  end
endmodule : tb
